// >>> icp_params.svh
// constants of the configuration port: offsets, fields, resets, timing
// assumes a 50 MHz system clock and an 8-bit register pointer
`ifndef ICP_PARAMS_SVH
`define ICP_PARAMS_SVH

`define ICP_TARGET_ADDR    7'h59
`define ICP_OFS_PROG_COUNT 8'h30
`define ICP_OFS_CTRL       8'h31
`define ICP_OFS_MEM_ADDR   8'h33
`define ICP_OFS_NVM_DATA   8'h34
`define ICP_OFS_SRAM_DATA  8'h35
`define ICP_OFS_UNLOCK     8'h38
`define ICP_CTRL_PROG_BIT  0
`define ICP_CTRL_BUSY_BIT  2
`define ICP_CTRL_SHADOW_BIT 6
`define ICP_UNLOCK_KEY     8'hBE
`define ICP_RESET_BYTE     8'h00
`define ICP_CLK_NS         20
`define ICP_GLITCH_NS      50
// a pulse just under the limit can still cover three samples
`define ICP_GLITCH_CYC     (`ICP_GLITCH_NS / `ICP_CLK_NS + 2)
`define ICP_PROG_TIME_NS   20000
`define ICP_PROG_CYC       (`ICP_PROG_TIME_NS / `ICP_CLK_NS)

`endif

// >>> icp_pkg.sv
// types of the configuration port
// assumes nothing beyond the constants header
`default_nettype none

package icp_pkg;
   typedef enum logic [2:0] {S_IDLE, S_RX, S_RX_ACK, S_TX, S_TX_ACK}
      icp_bus_state_t;
   typedef enum logic [1:0] {K_ADDR, K_PTR, K_DATA} icp_byte_kind_t;
   typedef enum logic [2:0] {C_LOAD, C_IDLE, C_SHADOW, C_PROG, C_WAIT}
      icp_copy_state_t;
endpackage : icp_pkg

`default_nettype wire

// >>> icp_byte_mem.sv
// 256 x 8 single-port memory, write and registered read
// assumes one address per cycle from a single owner mux
`default_nettype none

module icp_byte_mem
   import icp_pkg::*;
  (input  wire logic       clk,
   input  wire logic       wrEn,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wrData,
   output logic      [7:0] rdData);

   logic [7:0] store [0:255];

   always_ff @(posedge clk) begin
      if (wrEn) begin
         store[addr] <= wrData;
      end
      rdData <= store[addr];
   end
endmodule : icp_byte_mem

`default_nettype wire

// >>> icp_config_port.sv
// serial target port with register, shadow and nonvolatile copy engine
// assumes scl/sda pins asynchronous to clk; sda is open drain outside
`default_nettype none
`include "icp_params.svh"

module icp_config_port
   import icp_pkg::*;
  (input  wire logic clk,
   input  wire logic resetn,
   input  wire logic sclPin,
   input  wire logic sdaPin,
   output logic      sdaOut,
   output logic      sdaOe,
   output logic      nvmWriteBusy,
   output logic      configReady);

   function automatic logic isDataPort(input logic [7:0] p);
      return (p == `ICP_OFS_SRAM_DATA) || (p == `ICP_OFS_NVM_DATA);
   endfunction : isDataPort

   // data ports stream, so the pointer parks on them
   function automatic logic [7:0] nextPtr(input logic [7:0] p);
      return isDataPort(p) ? p : p + 8'h01;
   endfunction : nextPtr

   logic [1:0]      sync1_reg, sync2_reg, filt_reg, prev_reg;
   logic            sclRise, sclFall, startC, stopC, sdaF;
   icp_bus_state_t  state_reg;
   icp_byte_kind_t  kind_reg;
   logic [2:0]      bitCnt_reg;
   logic [7:0]      shift_reg, ptr_reg, txByte_reg, fetchPtrD_reg;
   logic            full_reg, readMode_reg, sdaOe_reg, fetchDly_reg;
   logic            addrMatch, wrStrobe, fetchFirst, fetchNext, fetchReq;
   logic [7:0]      fetchPtr, readValue;
   logic [7:0]      progCount_reg, key_reg, memAddr_reg, portAddr;
   logic            armFirst_reg, portOpen_reg, ctrlWr, portAccess;
   icp_copy_state_t cState_reg;
   logic [7:0]      cIdx_reg, cWrAddr_reg;
   logic            cPend_reg, cStop_reg, cRdEn, busy_reg, ready_reg;
   logic            shadowStart, progStart;
   logic [15:0]     timer_reg;
   logic            regsWe, sramWe, nvmWe;
   logic [7:0]      regsAddr, sramAddr, nvmAddr;
   logic [7:0]      regsWd, sramWd, nvmWd, regsRd, sramRd, nvmRd;

   // two-flop synchroniser, idle bus is high
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sync1_reg <= 2'h3;
         sync2_reg <= 2'h3;
      end else begin
         sync1_reg <= {sclPin, sdaPin};
         sync2_reg <= sync1_reg;
      end
   end

   // level must hold 4 samples; 3 could still pass a 45 ns pulse
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_filt
         logic [1:0] cnt_reg;
         always_ff @(posedge clk) begin
            if (!resetn) begin
               cnt_reg     <= 2'h0;
               filt_reg[g] <= 1'b1;
            end else if (sync2_reg[g] == filt_reg[g]) begin
               cnt_reg <= 2'h0;
            end else if (cnt_reg == 2'(`ICP_GLITCH_CYC - 1)) begin
               filt_reg[g] <= sync2_reg[g];
               cnt_reg     <= 2'h0;
            end else begin
               cnt_reg <= cnt_reg + 2'h1;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!resetn) begin
         prev_reg <= 2'h3;
      end else begin
         prev_reg <= filt_reg;
      end
   end

   // 50 MHz sampling leaves >10 samples per phase even at 1 MHz
   assign sdaF    = filt_reg[0];
   assign sclRise = filt_reg[1] & ~prev_reg[1];
   assign sclFall = ~filt_reg[1] & prev_reg[1];
   assign startC  = filt_reg[1] & prev_reg[1] & prev_reg[0] & ~sdaF;
   assign stopC   = filt_reg[1] & prev_reg[1] & ~prev_reg[0] & sdaF;

   assign addrMatch  = shift_reg[7:1] == `ICP_TARGET_ADDR;
   assign wrStrobe   = (state_reg == S_RX) && sclFall && full_reg &&
                       (kind_reg == K_DATA);
   assign fetchFirst = (state_reg == S_RX) && sclFall && full_reg &&
                       (kind_reg == K_ADDR) && addrMatch && shift_reg[0];
   assign fetchNext  = (state_reg == S_TX_ACK) && sclRise && !sdaF;
   assign fetchReq   = fetchFirst | fetchNext;
   assign fetchPtr   = fetchFirst ? ptr_reg : nextPtr(ptr_reg);

   // byte engine: shifts in on scl rise, shifts out and drives sda after scl fall
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_reg    <= S_IDLE;
         kind_reg     <= K_ADDR;
         bitCnt_reg   <= 3'h0;
         shift_reg    <= `ICP_RESET_BYTE;
         ptr_reg      <= `ICP_RESET_BYTE;
         full_reg     <= 1'b0;
         readMode_reg <= 1'b0;
         sdaOe_reg    <= 1'b0;
      end else if (stopC) begin
         state_reg <= S_IDLE;
         sdaOe_reg <= 1'b0;
      end else if (startC && ready_reg) begin
         state_reg  <= S_RX;
         kind_reg   <= K_ADDR;
         bitCnt_reg <= 3'h0;
         full_reg   <= 1'b0;
         sdaOe_reg  <= 1'b0;
      end else begin
         case (state_reg)
            S_RX: begin
               if (sclRise) begin
                  shift_reg  <= {shift_reg[6:0], sdaF};
                  bitCnt_reg <= bitCnt_reg + 3'h1;
                  if (bitCnt_reg == 3'h7) begin
                     full_reg <= 1'b1;
                  end
               end else if (sclFall && full_reg) begin
                  full_reg <= 1'b0;
                  if (kind_reg == K_ADDR && !addrMatch) begin
                     state_reg <= S_IDLE;
                  end else begin
                     sdaOe_reg <= 1'b1;
                     state_reg <= S_RX_ACK;
                     if (kind_reg == K_ADDR) begin
                        readMode_reg <= shift_reg[0];
                     end
                     if (kind_reg == K_PTR) begin
                        ptr_reg <= shift_reg;
                     end
                     if (kind_reg == K_DATA) begin
                        ptr_reg <= nextPtr(ptr_reg);
                     end
                  end
               end
            end
            S_RX_ACK: begin
               if (sclFall) begin
                  bitCnt_reg <= 3'h0;
                  if (kind_reg == K_ADDR && readMode_reg) begin
                     state_reg <= S_TX;
                     shift_reg <= txByte_reg;
                     sdaOe_reg <= ~txByte_reg[7];
                  end else begin
                     state_reg <= S_RX;
                     sdaOe_reg <= 1'b0;
                     kind_reg  <= (kind_reg == K_ADDR) ? K_PTR : K_DATA;
                  end
               end
            end
            S_TX: begin
               if (sclRise) begin
                  bitCnt_reg <= bitCnt_reg + 3'h1;
               end else if (sclFall) begin
                  if (bitCnt_reg == 3'h0) begin
                     sdaOe_reg <= 1'b0;
                     state_reg <= S_TX_ACK;
                  end else begin
                     shift_reg <= {shift_reg[6:0], 1'b0};
                     sdaOe_reg <= ~shift_reg[6];
                  end
               end
            end
            S_TX_ACK: begin
               if (sclRise) begin
                  ptr_reg <= nextPtr(ptr_reg);
                  if (sdaF) begin
                     state_reg <= S_IDLE;
                  end
               end else if (sclFall) begin
                  state_reg  <= S_TX;
                  bitCnt_reg <= 3'h0;
                  shift_reg  <= txByte_reg;
                  sdaOe_reg  <= ~txByte_reg[7];
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   // read data is fetched a whole scl phase before it is shifted out
   always_comb begin
      case (fetchPtrD_reg)
         `ICP_OFS_PROG_COUNT: readValue = progCount_reg;
         `ICP_OFS_CTRL:       readValue = 8'(busy_reg) << `ICP_CTRL_BUSY_BIT;
         `ICP_OFS_MEM_ADDR:   readValue = memAddr_reg;
         `ICP_OFS_UNLOCK:     readValue = key_reg;
         `ICP_OFS_SRAM_DATA:  readValue = sramRd;
         `ICP_OFS_NVM_DATA:   readValue = busy_reg ? 8'h00 : nvmRd;
         default:             readValue = regsRd;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         fetchDly_reg  <= 1'b0;
         fetchPtrD_reg <= `ICP_RESET_BYTE;
         txByte_reg    <= 8'hFF;
      end else begin
         fetchDly_reg  <= fetchReq;
         fetchPtrD_reg <= fetchPtr;
         if (fetchDly_reg) begin
            txByte_reg <= readValue;
         end
      end
   end

   // streaming port: first access uses the written address, later ones +1
   assign portAddr   = armFirst_reg ? memAddr_reg : memAddr_reg + 8'h01;
   assign ctrlWr     = wrStrobe && (ptr_reg == `ICP_OFS_CTRL);
   assign portAccess = portOpen_reg &&
      ((wrStrobe && ptr_reg == `ICP_OFS_SRAM_DATA) ||
       (fetchReq && isDataPort(fetchPtr)));

   always_ff @(posedge clk) begin
      if (!resetn) begin
         key_reg      <= `ICP_RESET_BYTE;
         memAddr_reg  <= `ICP_RESET_BYTE;
         armFirst_reg <= 1'b0;
         portOpen_reg <= 1'b0;
      end else begin
         if (wrStrobe && ptr_reg == `ICP_OFS_UNLOCK) begin
            key_reg <= shift_reg;
         end
         if (stopC) begin
            portOpen_reg <= 1'b0;
         end else if (wrStrobe && ptr_reg == `ICP_OFS_MEM_ADDR) begin
            memAddr_reg  <= shift_reg;
            armFirst_reg <= 1'b1;
            portOpen_reg <= 1'b1;
         end else if (portAccess) begin
            memAddr_reg  <= portAddr;
            armFirst_reg <= 1'b0;
         end
      end
   end

   // copy engine: load at power-up, shadow copy, nonvolatile program
   assign shadowStart = ctrlWr && shift_reg[`ICP_CTRL_SHADOW_BIT] &&
                        (cState_reg == C_IDLE);
   assign progStart   = ctrlWr && shift_reg[`ICP_CTRL_PROG_BIT] &&
                        !shift_reg[`ICP_CTRL_SHADOW_BIT] &&
                        (key_reg == `ICP_UNLOCK_KEY) &&
                        (cState_reg == C_IDLE);
   assign cRdEn = (cState_reg == C_LOAD || cState_reg == C_SHADOW ||
                   cState_reg == C_PROG) && !cStop_reg;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cState_reg    <= C_LOAD;
         cIdx_reg      <= 8'h00;
         cWrAddr_reg   <= 8'h00;
         cPend_reg     <= 1'b0;
         cStop_reg     <= 1'b0;
         timer_reg     <= 16'h0000;
         busy_reg      <= 1'b0;
         ready_reg     <= 1'b0;
         progCount_reg <= `ICP_RESET_BYTE;
      end else begin
         cPend_reg   <= cRdEn;
         cWrAddr_reg <= cIdx_reg;
         if (cRdEn) begin
            cIdx_reg <= cIdx_reg + 8'h01;
            if (cIdx_reg == 8'hFF) begin
               cStop_reg <= 1'b1;
            end
         end
         case (cState_reg)
            C_IDLE: begin
               cStop_reg <= 1'b0;
               if (shadowStart) begin
                  cState_reg <= C_SHADOW;
               end else if (progStart) begin
                  cState_reg <= C_PROG;
                  busy_reg   <= 1'b1;
               end
            end
            C_LOAD, C_SHADOW, C_PROG: begin
               if (cStop_reg && !cPend_reg) begin
                  ready_reg  <= 1'b1;
                  timer_reg  <= 16'h0000;
                  cState_reg <= (cState_reg == C_PROG) ? C_WAIT : C_IDLE;
               end
            end
            C_WAIT: begin
               timer_reg <= timer_reg + 16'h0001;
               if (timer_reg == 16'(`ICP_PROG_CYC - 1)) begin
                  busy_reg      <= 1'b0;
                  progCount_reg <= progCount_reg + 8'h01;
                  cState_reg    <= C_IDLE;
               end
            end
            default: cState_reg <= C_IDLE;
         endcase
      end
   end

   // copy engine owns the memories while it runs
   always_comb begin
      regsWe   = 1'b0;
      regsAddr = fetchPtr;
      regsWd   = shift_reg;
      sramWe   = 1'b0;
      sramAddr = portAddr;
      sramWd   = shift_reg;
      nvmWe    = 1'b0;
      nvmAddr  = portAddr;
      nvmWd    = sramRd;
      if (cState_reg == C_LOAD) begin
         regsWe   = cPend_reg;
         regsAddr = cWrAddr_reg;
         regsWd   = nvmRd;
         nvmAddr  = cIdx_reg;
      end else if (cState_reg == C_SHADOW) begin
         regsAddr = cIdx_reg;
         sramWe   = cPend_reg;
         sramAddr = cWrAddr_reg;
         sramWd   = regsRd;
      end else if (cState_reg == C_PROG) begin
         sramAddr = cIdx_reg;
         nvmWe    = cPend_reg;
         nvmAddr  = cWrAddr_reg;
      end else begin
         // margining words land here like any register but the program count
         if (wrStrobe && ptr_reg != `ICP_OFS_PROG_COUNT) begin
            regsWe   = 1'b1;
            regsAddr = ptr_reg;
         end
         sramWe = wrStrobe && portOpen_reg &&
                  (ptr_reg == `ICP_OFS_SRAM_DATA);
      end
   end

   icp_byte_mem u_regs (.clk(clk), .wrEn(regsWe), .addr(regsAddr),
                        .wrData(regsWd), .rdData(regsRd));
   icp_byte_mem u_sram (.clk(clk), .wrEn(sramWe), .addr(sramAddr),
                        .wrData(sramWd), .rdData(sramRd));
   icp_byte_mem u_nvm  (.clk(clk), .wrEn(nvmWe), .addr(nvmAddr),
                        .wrData(nvmWd), .rdData(nvmRd));

   assign sdaOut       = 1'b0;
   assign sdaOe        = sdaOe_reg;
   assign nvmWriteBusy = busy_reg;
   assign configReady  = ready_reg;

   property p_addr_miss;
      @(posedge clk) disable iff (!resetn)
      (state_reg == S_RX && sclFall && full_reg && kind_reg == K_ADDR &&
       !addrMatch && !stopC) |=> (state_reg == S_IDLE) && !sdaOe_reg;
   endproperty
   a_addr_miss: assert property (p_addr_miss)
      else $error("foreign address was not ignored");

   property p_ack_drive;
      @(posedge clk) disable iff (!resetn)
      (state_reg == S_RX_ACK && !sclFall && !stopC && !startC)
         |-> sdaOe_reg;
   endproperty
   a_ack_drive: assert property (p_ack_drive)
      else $error("sda not held low during acknowledge");

   property p_nack_idle;
      @(posedge clk) disable iff (!resetn)
      (state_reg == S_TX_ACK && sclRise && sdaF) |=>
         (state_reg == S_IDLE) && !sdaOe_reg;
   endproperty
   a_nack_idle: assert property (p_nack_idle)
      else $error("non-acknowledge did not end the read");

   property p_glitch;
      @(posedge clk) disable iff (!resetn)
      !$stable(filt_reg[1]) |-> ($past(sync2_reg[1], 1) == filt_reg[1]) &&
         ($past(sync2_reg[1], 2) == filt_reg[1]) &&
         ($past(sync2_reg[1], 3) == filt_reg[1]) &&
         ($past(sync2_reg[1], 4) == filt_reg[1]);
   endproperty
   a_glitch: assert property (p_glitch)
      else $error("short pulse reached the filtered clock");

   property p_ptr_inc;
      @(posedge clk) disable iff (!resetn)
      (wrStrobe && !isDataPort(ptr_reg)) |=>
         ptr_reg == $past(ptr_reg) + 8'h01;
   endproperty
   a_ptr_inc: assert property (p_ptr_inc)
      else $error("register pointer did not advance");

   property p_busy_hold;
      @(posedge clk) disable iff (!resetn)
      $rose(busy_reg) |-> busy_reg [*8] ##0 (cState_reg == C_PROG);
   endproperty
   a_busy_hold: assert property (p_busy_hold)
      else $error("busy dropped early");

   property p_key;
      @(posedge clk) disable iff (!resetn)
      $rose(busy_reg) |-> $past(key_reg) == `ICP_UNLOCK_KEY;
   endproperty
   a_key: assert property (p_key)
      else $error("programming started without unlock key");

   property p_count;
      @(posedge clk) disable iff (!resetn)
      $fell(busy_reg) |-> (progCount_reg == $past(progCount_reg) + 8'h01)
         && (cState_reg == C_IDLE);
   endproperty
   a_count: assert property (p_count)
      else $error("program counter not incremented");

   property p_busy_ignore;
      @(posedge clk) disable iff (!resetn)
      (ctrlWr && busy_reg) |=> busy_reg && $stable(progCount_reg);
   endproperty
   a_busy_ignore: assert property (p_busy_ignore)
      else $error("request during busy was not ignored");

   property p_port_write;
      @(posedge clk) disable iff (!resetn)
      (wrStrobe && portOpen_reg && ptr_reg == `ICP_OFS_SRAM_DATA &&
       cState_reg == C_IDLE) |=> memAddr_reg == $past(portAddr);
   endproperty
   a_port_write: assert property (p_port_write)
      else $error("shadow port address not advanced");

   c_read_ack: cover property (@(posedge clk) disable iff (!resetn)
      fetchNext);
   c_prog_done: cover property (@(posedge clk) disable iff (!resetn)
      $fell(busy_reg));
   c_shadow: cover property (@(posedge clk) disable iff (!resetn)
      shadowStart);
endmodule : icp_config_port

`default_nettype wire

// >>> icp_host_model.sv
// serial bus controller model that plays the host side of the port
// assumes the bench resolves sda as open drain with a pull-up
`default_nettype none

module icp_host_model
  (input  wire logic clk,
   output logic      scl,
   output logic      sdaLow,
   input  wire logic sdaLine);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      scl = 1'b1;
      sdaLow = 1'b0;
   end

   // every change lands 1 ns after a clk edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic start_c;
      sdaLow = 1'b1;
      tick(4);
      scl = 1'b0;
   endtask : start_c

   task automatic rstart;
      tick(8);
      sdaLow = 1'b0;
      tick(4);
      scl = 1'b1;
      tick(4);
      sdaLow = 1'b1;
      tick(4);
      scl = 1'b0;
   endtask : rstart

   task automatic stop_c;
      tick(8);
      sdaLow = 1'b1;
      tick(4);
      scl = 1'b1;
      tick(4);
      sdaLow = 1'b0;
      tick(6);
   endtask : stop_c

   // scl high for 40 ns, under the glitch limit
   task automatic spike;
      tick(8);
      scl = 1'b1;
      tick(2);
      scl = 1'b0;
   endtask : spike

   // long low phase: the port answers 6 to 7 clk after each fall
   task automatic clk_bit(input logic drvLow, output logic seen);
      tick(8);
      sdaLow = drvLow;
      tick(4);
      scl = 1'b1;
      tick(3);
      seen = sdaLine;
      tick(2);
      scl = 1'b0;
   endtask : clk_bit

   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(~b[i], s);
      clk_bit(1'b0, s);
      ack = ~s;
   endtask : wr_byte

   task automatic rd_byte(input logic ackIt, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b0, s);
         b[i] = s;
      end
      clk_bit(ackIt, s);
   endtask : rd_byte
endmodule : icp_host_model

`default_nettype wire

// >>> icp_config_port_bench.sv
// self-checking bench for the serial configuration port
// assumes icp_host_model as bus controller and a pull-up on sda
`default_nettype none

module icp_config_port_bench;
   timeunit 1ns;
   timeprecision 1ns;

   logic      clk = 1'b0;
   logic      resetn = 1'b0;
   logic      sclPin;
   logic      hostLow;
   logic      sdaOut;
   logic      sdaOe;
   logic      nvmWriteBusy;
   logic      configReady;
   logic      ack;
   logic [7:0] rd;
   int        error_cnt = 0;
   int        total_checks = 0;
   wire logic sdaLine = ~(hostLow | (sdaOe & ~sdaOut));

   always #10 clk = ~clk;

   icp_config_port i_icp_config_port (.clk(clk), .resetn(resetn),
      .sclPin(sclPin), .sdaPin(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .nvmWriteBusy(nvmWriteBusy), .configReady(configReady));
   icp_host_model i_icp_host_model (.clk(clk), .scl(sclPin),
      .sdaLow(hostLow), .sdaLine(sdaLine));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic put(input logic [7:0] b, input logic expAck);
      i_icp_host_model.wr_byte(b, ack);
      chk({7'h00, ack}, {7'h00, expAck});
   endtask : put

   task automatic set_ptr(input logic [7:0] p);
      i_icp_host_model.start_c();
      put(8'hB2, 1'b1);
      put(p, 1'b1);
   endtask : set_ptr

   task automatic to_read;
      i_icp_host_model.rstart();
      put(8'hB3, 1'b1);
   endtask : to_read

   task automatic rd_reg(input logic [7:0] p, output logic [7:0] b);
      set_ptr(p);
      to_read();
      i_icp_host_model.rd_byte(1'b0, b);
      i_icp_host_model.stop_c();
   endtask : rd_reg

   task automatic wr_reg(input logic [7:0] p, input logic [7:0] d);
      set_ptr(p);
      put(d, 1'b1);
      i_icp_host_model.stop_c();
   endtask : wr_reg

   // opens data port p at address a inside one transaction
   task automatic open_port(input logic [7:0] a, input logic [7:0] p);
      set_ptr(8'h33);
      put(a, 1'b1);
      i_icp_host_model.rstart();
      put(8'hB2, 1'b1);
      put(p, 1'b1);
   endtask : open_port

   task automatic open_sram(input logic [7:0] a);
      open_port(a, 8'h35);
   endtask : open_sram

   task automatic t_burst;
      set_ptr(8'h40);
      i_icp_host_model.spike();
      put(8'hA5, 1'b1);
      put(8'h3C, 1'b1);
      i_icp_host_model.stop_c();
      set_ptr(8'h40);
      to_read();
      i_icp_host_model.rd_byte(1'b1, rd);
      chk(rd, 8'hA5);
      i_icp_host_model.rd_byte(1'b0, rd);
      chk(rd, 8'h3C);
      i_icp_host_model.stop_c();
      $display("test burst done");
   endtask : t_burst

   task automatic t_addr;
      i_icp_host_model.start_c();
      put(8'hB4, 1'b0);
      i_icp_host_model.stop_c();
      i_icp_host_model.start_c();
      put(8'hB1, 1'b0);
      i_icp_host_model.stop_c();
      $display("test address done");
   endtask : t_addr

   task automatic t_shadow;
      wr_reg(8'h31, 8'h40);
      i_icp_host_model.tick(300);
      open_sram(8'h41);
      to_read();
      i_icp_host_model.rd_byte(1'b0, rd);
      chk(rd, 8'h3C);
      i_icp_host_model.stop_c();
      open_sram(8'h80);
      put(8'h11, 1'b1);
      put(8'h22, 1'b1);
      i_icp_host_model.stop_c();
      open_sram(8'h80);
      to_read();
      i_icp_host_model.rd_byte(1'b1, rd);
      chk(rd, 8'h11);
      i_icp_host_model.rd_byte(1'b0, rd);
      chk(rd, 8'h22);
      i_icp_host_model.stop_c();
      $display("test shadow done");
   endtask : t_shadow

   task automatic t_prog;
      int n;
      wr_reg(8'h30, 8'h77);
      rd_reg(8'h30, rd);
      chk(rd, 8'h00);
      wr_reg(8'h31, 8'h01);
      i_icp_host_model.tick(300);
      chk({7'h00, nvmWriteBusy}, 8'h00);
      wr_reg(8'h38, 8'hBE);
      wr_reg(8'h31, 8'h01);
      // pointer traffic only, so no need to wait out the copy
      i_icp_host_model.tick(20);
      chk({7'h00, nvmWriteBusy}, 8'h01);
      wr_reg(8'h31, 8'h01);
      rd_reg(8'h31, rd);
      chk(rd & 8'h04, 8'h04);
      n = 0;
      while (nvmWriteBusy !== 1'b0 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      chk({7'h00, nvmWriteBusy}, 8'h00);
      rd_reg(8'h30, rd);
      chk(rd, 8'h01);
      open_port(8'h80, 8'h34);
      to_read();
      i_icp_host_model.rd_byte(1'b1, rd);
      chk(rd, 8'h11);
      i_icp_host_model.rd_byte(1'b0, rd);
      chk(rd, 8'h22);
      i_icp_host_model.stop_c();
      wr_reg(8'h38, 8'h00);
      wr_reg(8'h31, 8'h01);
      i_icp_host_model.tick(20);
      chk({7'h00, nvmWriteBusy}, 8'h00);
      $display("test program done");
   endtask : t_prog

   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim

   initial begin
      int n;
      n = 0;
      repeat (20) @(posedge clk);
      #1 resetn = 1'b1;
      while (configReady !== 1'b1 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      chk({7'h00, configReady}, 8'h01);
      t_burst();
      t_addr();
      t_shadow();
      t_prog();
      end_sim();
   end

   // whole run is about 13500 clk; 50000 clk leaves ample margin
   initial begin
      #1000000;
      error_cnt++;
      end_sim();
   end
endmodule : icp_config_port_bench

`default_nettype wire
